//--- common/fdm_pkg.sv
// Shared constants for the flash data memory controller
package fdm_pkg;
  // Memory control register address in the special register space
  localparam logic [7:0]  MEMORY_CONTROL_ADDR = 8'h96;
  // Memory control field positions
  localparam int          BIT_CODE_PROG       = 7;
  localparam int          BIT_AUTO_ERASE      = 6;
  localparam int          BIT_BUF_LOAD        = 5;
  localparam int          BIT_NV_WEN          = 4;
  localparam int          BIT_DF_EN           = 3;
  localparam int          BIT_ERR             = 2;
  localparam int          BIT_BUSY            = 1;
  localparam int          BIT_WRT_INH         = 0;
  localparam logic [4:0]  CTRL_RESET          = 5'h00;
  // Address map of the external data space
  localparam logic [15:0] FLASH_LAST_ADDR     = 16'h00FF;
  localparam logic [15:0] CODE_LAST_ADDR      = 16'h1FFF;
  localparam int          FLASH_BYTES         = 256;
  localparam int          FLASH_AW            = 8;
  localparam int          PAGE_BYTES          = 128;
  localparam int          HALF_BYTES          = 64;
  localparam int          HALF_AW             = 6;
  localparam logic [7:0]  ERASED_BYTE         = 8'hFF;
  // Routing target codes
  localparam logic [1:0]  TGT_EXT             = 2'h0;
  localparam logic [1:0]  TGT_FLASH           = 2'h1;
  localparam logic [1:0]  TGT_CODE            = 2'h2;
  // Write sequence duration
  localparam int          CLK_MHZ             = 125;
  localparam int          PROG_TIME_US        = 4000;
  localparam int          PROG_CYCLES         = PROG_TIME_US * CLK_MHZ;
  localparam int          CNT_W               = 20;
  // Sequencer states
  typedef enum logic [3:0]
  {
    S_IDLE  = 4'h1,
    S_ERASE = 4'h2,
    S_PROG  = 4'h4,
    S_WAIT  = 4'h8
  } fdm_state_e;
endpackage

//--- hdl/fdm_mem.sv
// Byte memory with a registered read port and a write port that can AND into the cell
module fdm_mem #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic          i_and_mode,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];

  // AND mode only clears bits, plain mode stores the byte
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_and_mode ? (mem[i_waddr] & i_wdata) : i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // fdm_mem

//--- hdl/fdm_ctrl.sv
// Summary of operation
// - External-only mapping sends every move outside.
// - Addresses above internal range go external.
// - Flash at 0000H-00FFH when enabled, no code access.
// - Flash disabled, no code access, means its range goes external.
// - Only 16-bit pointer moves reach flash.
// - Reads are plain; writes take milliseconds.
// - Internal execution holds the CPU until done.
// - External execution runs on, busy flag reports.
// - Flash write needs write enable and flash enable.
// - Clear write enable blocks all programming.
// - Programming only clears bits, ANDing data.
// - Erase sets whole page to FFH.
// - Two 128-byte pages, 64-byte buffer.
// - Half pages 00H-3FH and 40H-7FH written separately.
// - Buffer-load mode stores byte, no programming.
// - Committing write adds byte, starts, picks half.
// - Commit with empty buffer writes one byte.
// - Buffer empties after every write operation.
// - Auto-erase wipes whole page, then programs half.
// - Brown-out refuses start, aborts with error.
// - Register layout; bits 7..3 reset to zero.
// - Code access redirects 16-bit moves at 0000H-1FFFH to code.
module fdm_ctrl #(
  parameter int P_PROG_CYCLES = fdm_pkg::PROG_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  input  wire logic        i_xmove_req,
  input  wire logic        i_xmove_wr,
  input  wire logic        i_xmove_ptr16,
  input  wire logic [15:0] i_xmove_addr,
  input  wire logic [7:0]  i_xmove_wdata,
  output logic             o_xmove_ack,
  output logic      [1:0]  o_xmove_target,
  output logic      [7:0]  o_xmove_rdata,
  input  wire logic        i_external_only_mapping,
  input  wire logic        i_code_prog_fuse,
  input  wire logic        i_exec_internal,
  input  wire logic        i_brownout,
  output logic             o_busy,
  output logic             o_cpu_hold
);
  localparam logic [fdm_pkg::CNT_W-1:0] PROG_LAST = (fdm_pkg::CNT_W)'(P_PROG_CYCLES - 1);

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [2:0]  bo_sync_q;
  logic        bo_q, bo_d;
  // Control bits 7..3 and the error flag
  logic [4:0]  ctrl_q, ctrl_d;
  logic        err_q, err_d;
  fdm_pkg::fdm_state_e state_q, state_d;
  logic [7:0]  idx_q, idx_d;
  logic        pvld_q, pvld_d;
  logic [5:0]  pidx_q, pidx_d;
  logic [fdm_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [63:0] loaded_q, loaded_d;
  logic        page_q, page_d, half_q, half_d;
  logic        hold_int_q, hold_int_d, busy_q, busy_d, hold_q, hold_d;
  logic [7:0]  sfr_rdata_q, sfr_rdata_d;
  logic        ack_q;
  logic [1:0]  tgt_q, tgt_d;
  logic [7:0]  flash_rdata, buf_rdata;
  // Memory port controls
  logic        buf_we, fl_we, fl_and;
  logic [7:0]  fl_waddr, fl_wdata;
  logic [5:0]  buf_raddr;
  // Decoded access
  logic        code_prog_eff, in_flash, reg_hit, fl_write, commit;

  // Reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn) rst_sync_q <= 2'h0;
    else         rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Brown-out pin filter: a change counts once stages two and three agree
  always_comb
  begin
    bo_d = bo_q;
    if (bo_sync_q[1] == bo_sync_q[2]) bo_d = bo_sync_q[2];
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bo_sync_q <= 3'h0;
      bo_q      <= 1'b0;
    end
    else
    begin
      bo_sync_q <= {bo_sync_q[1:0], i_brownout};
      bo_q      <= bo_d;
    end
  end

  // Address routing; the code bit is forced low when its fuse is off
  assign code_prog_eff = ctrl_q[fdm_pkg::BIT_CODE_PROG-3] & i_code_prog_fuse;
  assign in_flash = i_xmove_ptr16 && !i_external_only_mapping && !code_prog_eff
                    && ctrl_q[fdm_pkg::BIT_DF_EN-3]
                    && (i_xmove_addr <= fdm_pkg::FLASH_LAST_ADDR);
  assign reg_hit  = i_sfr_wr && (i_sfr_addr == fdm_pkg::MEMORY_CONTROL_ADDR);
  // Programming path needs both enable bits
  assign fl_write = i_xmove_req && i_xmove_wr && in_flash
                    && ctrl_q[fdm_pkg::BIT_NV_WEN-3] && (state_q == fdm_pkg::S_IDLE);
  assign commit   = fl_write && !ctrl_q[fdm_pkg::BIT_BUF_LOAD-3];

  // Every accepted flash write lands in the buffer, the commit byte too
  assign buf_we    = fl_write;
  assign buf_raddr = idx_q[5:0];

  // Register file, sequencer and flash port drive
  always_comb
  begin
    ctrl_d      = ctrl_q;
    err_d       = err_q;
    state_d     = state_q;
    idx_d       = idx_q;
    pvld_d      = 1'b0;
    pidx_d      = pidx_q;
    cnt_d       = cnt_q;
    loaded_d    = loaded_q;
    page_d      = page_q;
    half_d      = half_q;
    hold_int_d  = hold_int_q;
    fl_we       = 1'b0;
    fl_and      = 1'b0;
    fl_waddr    = 8'h00;
    fl_wdata    = fdm_pkg::ERASED_BYTE;
    // Busy and inhibit bits are not stored, so writes to them vanish
    if (reg_hit)
    begin
      ctrl_d = i_sfr_wdata[7:3];
      ctrl_d[fdm_pkg::BIT_CODE_PROG-3] = i_sfr_wdata[fdm_pkg::BIT_CODE_PROG] & i_code_prog_fuse;
      if (!i_sfr_wdata[fdm_pkg::BIT_ERR]) err_d = 1'b0;
    end
    unique case (state_q)
      fdm_pkg::S_IDLE:
      begin
        idx_d = 8'h00;
        cnt_d = '0;
        if (fl_write) loaded_d[i_xmove_addr[5:0]] = 1'b1;
        if (commit)
        begin
          page_d     = i_xmove_addr[7];
          half_d     = i_xmove_addr[6];
          hold_int_d = i_exec_internal;
          // A start under brown-out is refused and its loaded bytes are dropped
          if (bo_q) loaded_d = '0;
          else state_d = ctrl_q[fdm_pkg::BIT_AUTO_ERASE-3] ? fdm_pkg::S_ERASE
                                                              : fdm_pkg::S_PROG;
        end
      end
      fdm_pkg::S_ERASE:
      begin
        // One byte per cycle across both halves of the page
        fl_we    = 1'b1;
        fl_waddr = {page_q, idx_q[6:0]};
        fl_wdata = fdm_pkg::ERASED_BYTE;
        idx_d    = idx_q + 8'h01;
        if (idx_q == 8'(fdm_pkg::PAGE_BYTES - 1))
        begin
          idx_d   = 8'h00;
          state_d = fdm_pkg::S_PROG;
        end
      end
      fdm_pkg::S_PROG:
      begin
        // Buffer read is registered, so the write trails the read by a cycle
        if (idx_q < 8'(fdm_pkg::HALF_BYTES))
        begin
          pvld_d = 1'b1;
          pidx_d = idx_q[5:0];
          idx_d  = idx_q + 8'h01;
        end
        else if (!pvld_q) state_d = fdm_pkg::S_WAIT;
        if (pvld_q && loaded_q[pidx_q])
        begin
          fl_we    = 1'b1;
          fl_and   = 1'b1;
          fl_waddr = {page_q, half_q, pidx_q};
          fl_wdata = buf_rdata;
        end
      end
      fdm_pkg::S_WAIT:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == PROG_LAST)
        begin
          state_d  = fdm_pkg::S_IDLE;
          loaded_d = '0;
        end
      end
      default: state_d = fdm_pkg::S_IDLE;
    endcase
    // Brown-out during a sequence aborts it and flags the error
    if (state_q != fdm_pkg::S_IDLE && bo_q)
    begin
      state_d  = fdm_pkg::S_IDLE;
      loaded_d = '0;
      err_d    = 1'b1;
    end
    busy_d = (state_d != fdm_pkg::S_IDLE);
    hold_d = busy_d && ((state_q == fdm_pkg::S_IDLE) ? i_exec_internal : hold_int_q);
    sfr_rdata_d = {ctrl_q, err_q, busy_q, ~bo_q};
    // Route target; whatever no internal resource claims goes to external memory
    tgt_d = in_flash ? fdm_pkg::TGT_FLASH
          : (code_prog_eff && i_xmove_ptr16 && !i_external_only_mapping
             && i_xmove_addr <= fdm_pkg::CODE_LAST_ADDR) ? fdm_pkg::TGT_CODE
          : fdm_pkg::TGT_EXT;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q      <= fdm_pkg::CTRL_RESET;
      err_q       <= 1'b0;
      state_q     <= fdm_pkg::S_IDLE;
      idx_q       <= 8'h00;
      pvld_q      <= 1'b0;
      pidx_q      <= 6'h00;
      cnt_q       <= '0;
      loaded_q    <= '0;
      page_q      <= 1'b0;
      half_q      <= 1'b0;
      hold_int_q  <= 1'b0;
      busy_q      <= 1'b0;
      hold_q      <= 1'b0;
      sfr_rdata_q <= 8'h00;
      ack_q       <= 1'b0;
      tgt_q       <= fdm_pkg::TGT_EXT;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      err_q       <= err_d;
      state_q     <= state_d;
      idx_q       <= idx_d;
      pvld_q      <= pvld_d;
      pidx_q      <= pidx_d;
      cnt_q       <= cnt_d;
      loaded_q    <= loaded_d;
      page_q      <= page_d;
      half_q      <= half_d;
      hold_int_q  <= hold_int_d;
      busy_q      <= busy_d;
      hold_q      <= hold_d;
      sfr_rdata_q <= sfr_rdata_d;
      ack_q       <= i_xmove_req;
      tgt_q       <= i_xmove_req ? tgt_d : tgt_q;
    end
  end

  // Flash array; its read port serves the CPU only
  fdm_mem #(.DEPTH(fdm_pkg::FLASH_BYTES), .AW(fdm_pkg::FLASH_AW)) u_flash (
    .i_clk      (i_clk),
    .i_we       (fl_we),
    .i_and_mode (fl_and),
    .i_waddr    (fl_waddr),
    .i_wdata    (fl_wdata),
    .i_raddr    (i_xmove_addr[7:0]),
    .o_rdata    (flash_rdata)
  );

  // Half-page load buffer
  fdm_mem #(.DEPTH(fdm_pkg::HALF_BYTES), .AW(fdm_pkg::HALF_AW)) u_buf (
    .i_clk      (i_clk),
    .i_we       (buf_we),
    .i_and_mode (1'b0),
    .i_waddr    (i_xmove_addr[5:0]),
    .i_wdata    (i_xmove_wdata),
    .i_raddr    (buf_raddr),
    .o_rdata    (buf_rdata)
  );

  assign o_sfr_rdata    = sfr_rdata_q;
  assign o_xmove_ack    = ack_q;
  assign o_xmove_target = tgt_q;
  assign o_xmove_rdata  = flash_rdata; // Read port is itself a register
  assign o_busy         = busy_q;
  assign o_cpu_hold     = hold_q;

  // Checks
  sequence s_req_ext;
    i_xmove_req && !i_external_only_mapping && i_xmove_ptr16;
  endsequence
  sequence s_commit_ok;
    commit && !bo_q;
  endsequence

  AST_EXT_ONLY: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_xmove_req && i_external_only_mapping |=> o_xmove_target == fdm_pkg::TGT_EXT)
    else $error("external-only move not routed outside");
  AST_HIGH_EXT: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_xmove_req && i_xmove_addr > fdm_pkg::CODE_LAST_ADDR |=> o_xmove_target == fdm_pkg::TGT_EXT)
    else $error("high address not routed outside");
  AST_FLASH_MAP: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_req_ext ##0 (!code_prog_eff && ctrl_q[0] && i_xmove_addr <= fdm_pkg::FLASH_LAST_ADDR)
    |=> o_xmove_target == fdm_pkg::TGT_FLASH)
    else $error("flash range not mapped");
  AST_DF_OFF: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_xmove_req && !ctrl_q[0] && !code_prog_eff |=> o_xmove_target == fdm_pkg::TGT_EXT)
    else $error("disabled flash reached");
  AST_PTR8: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_xmove_req && !i_xmove_ptr16 |=> o_xmove_target == fdm_pkg::TGT_EXT)
    else $error("8-bit pointer reached internal memory");
  AST_NO_WEN: assert property (@(posedge i_clk) disable iff (!rst_n)
    !o_busy && state_q == fdm_pkg::S_IDLE && i_xmove_req && !ctrl_q[1] |=> !o_busy)
    else $error("programming started without write enable");
  AST_LOAD_ONLY: assert property (@(posedge i_clk) disable iff (!rst_n)
    fl_write && ctrl_q[2] |=> state_q == fdm_pkg::S_IDLE && loaded_q[$past(i_xmove_addr[5:0])])
    else $error("buffer load did not just store");
  AST_START: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_commit_ok ##1 !bo_q |-> o_busy)
    else $error("committing write did not start");
  AST_BO_ERR: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_q != fdm_pkg::S_IDLE && bo_q |=> err_q && !o_busy && loaded_q == '0)
    else $error("brown-out abort missing");
  AST_HOLD: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_commit_ok ##0 i_exec_internal ##1 o_busy [*3] |-> o_cpu_hold)
    else $error("CPU not held in internal execution");
endmodule // fdm_ctrl

//--- testbench/fdm_cpu_model.sv
// Core side of the data move port: one move at a time, request held for one edge
module fdm_cpu_model
(
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [7:0]  i_rdata,
  input  wire logic [1:0]  i_target,
  output logic             o_req,
  output logic             o_wr,
  output logic             o_ptr16,
  output logic      [15:0] o_addr,
  output logic      [7:0]  o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       ack_q;
  logic [7:0] rd_q;
  logic [1:0] tgt_q;

  // Idle bus at time zero
  initial
  begin
    o_req   = 1'b0;
    o_wr    = 1'b0;
    o_ptr16 = 1'b0;
    o_addr  = 16'h0000;
    o_wdata = 8'h00;
  end

  // Request is a one-edge pulse; address and data stay until the answer edge
  task automatic mv(input logic wr, input logic p16, input logic [15:0] addr,
                    input logic [7:0] data, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    #1;
    o_req   = 1'b1;
    o_wr    = wr;
    o_ptr16 = p16;
    o_addr  = addr;
    o_wdata = data;
    @(posedge i_clk);
    #1;
    o_req   = 1'b0;
    ack_q   = i_ack;
    rd_q    = i_rdata;
    tgt_q   = i_target;
    // Released lines show the inverse so a stale value cannot pass for a live one
    o_addr  = ~addr;
    o_wdata = ~data;
  endtask
endmodule // fdm_cpu_model

//--- testbench/flash_data_memory_ctrl_tb.sv
// Self-checking bench for the flash data memory controller
module flash_data_memory_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rstn, sfr_wr, ext_only, fuse, exec_int, bo;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xrd, xwd;
  logic        req, xwr, p16, ack, busy, hold, cp, de, eo, ptr;
  logic [15:0] xaddr, lfsr, a;
  logic [1:0]  tgt;
  logic [7:0]  bufd [7];
  logic [15:0] masks [4] = '{16'h00FF, 16'h01FF, 16'h1FFF, 16'hFFFF};
  logic [15:0] corners [4] = '{16'h00FF, 16'h0100, 16'h1FFF, 16'h2000};
  int          error_cnt, n_compared;

  fdm_ctrl #(.P_PROG_CYCLES(16)) u_dut (
    .i_clk(clk), .i_rstn(rstn), .i_sfr_wr(sfr_wr), .i_sfr_addr(sfr_addr),
    .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata), .i_xmove_req(req),
    .i_xmove_wr(xwr), .i_xmove_ptr16(p16), .i_xmove_addr(xaddr), .i_xmove_wdata(xwd),
    .o_xmove_ack(ack), .o_xmove_target(tgt), .o_xmove_rdata(xrd),
    .i_external_only_mapping(ext_only), .i_code_prog_fuse(fuse),
    .i_exec_internal(exec_int), .i_brownout(bo), .o_busy(busy), .o_cpu_hold(hold));

  fdm_cpu_model u_cpu (
    .i_clk(clk), .i_ack(ack), .i_rdata(xrd), .i_target(tgt), .o_req(req),
    .o_wr(xwr), .o_ptr16(p16), .o_addr(xaddr), .o_wdata(xwd));

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  // Sixteen-bit maximal-length shift register; the fixed seed keeps every run the same
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd();
    lfsr = lfsr_next(lfsr);
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register write; read-back lands on the edge after the write edge
  task automatic sfr(input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_wr    = 1'b1;
    sfr_addr  = fdm_pkg::MEMORY_CONTROL_ADDR;
    sfr_wdata = d;
    @(posedge clk);
    #1;
    sfr_wr    = 1'b0;
    sfr_wdata = ~d;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [1:0] exp_tgt(input logic e, input logic c, input logic f,
                                         input logic p, input logic [15:0] ad);
    if (e)
      return 2'h0;
    if (c)
      return (p && ad <= 16'h1FFF) ? 2'h2 : 2'h0;
    if (f && p && ad <= 16'h00FF)
      return 2'h1;
    return 2'h0;
  endfunction

  task automatic rdchk(input logic [15:0] ad, input logic [7:0] exp);
    u_cpu.mv(1'b0, 1'b1, ad, 8'h00, int'(lfsr[1:0]));
    rnd();
    chk("ack", 16'(u_cpu.ack_q), 16'h1);
    chk("rdata", 16'(u_cpu.rd_q), 16'(exp));
    chk("rd_target", 16'(u_cpu.tgt_q), 16'(fdm_pkg::TGT_FLASH));
  endtask

  // Bounded poll of busy, as external code must do
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy_end", 16'(busy), 16'h0);
  endtask

  task automatic wr_flash(input logic [15:0] ad, input logic [7:0] d, input logic internal);
    exec_int = internal;
    u_cpu.mv(1'b1, 1'b1, ad, d, 0);
    chk("busy_start", 16'(busy), 16'h1);
    chk("cpu_hold", 16'(hold), 16'(internal));
    wait_idle();
  endtask

  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well above the thousand-odd cycles the sequence needs
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0; rstn = 1'b0; sfr_wr = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
    ext_only = 1'b0; fuse = 1'b0; exec_int = 1'b0; bo = 1'b0;
    lfsr = 16'h5DE3; error_cnt = 0; n_compared = 0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("ctrl_reset", 16'(sfr_rdata), 16'h0001);
    sfr(8'hFF);
    chk("ctrl_status_ro", 16'(sfr_rdata), 16'h0079);
    // Random mapping settings against random and boundary addresses
    repeat (48)
    begin
      rnd();
      {ptr, eo, de, cp} = lfsr[4:1];
      fuse = lfsr[5];
      ext_only = eo;
      sfr({cp, 3'b000, de, 3'b000});
      chk("code_access_bit", 16'(sfr_rdata[7]), 16'(cp & fuse));
      rnd();
      a = lfsr[7] ? corners[lfsr[9:8]] : (lfsr & masks[lfsr[11:10]]);
      u_cpu.mv(1'b0, ptr, a, 8'h00, int'(lfsr[13:12]));
      chk("target", 16'(u_cpu.tgt_q), 16'(exp_tgt(eo, cp & fuse, de, ptr, a)));
    end
    // Hand corners: code access outranks flash, external-only outranks both
    fuse = 1'b1;
    ext_only = 1'b0;
    sfr(8'h88);
    u_cpu.mv(1'b0, 1'b1, 16'h00FF, 8'h00, 0);
    chk("corner_code", 16'(u_cpu.tgt_q), 16'(fdm_pkg::TGT_CODE));
    ext_only = 1'b1;
    u_cpu.mv(1'b0, 1'b1, 16'h0000, 8'h00, 0);
    chk("corner_ext_only", 16'(u_cpu.tgt_q), 16'(fdm_pkg::TGT_EXT));
    fuse = 1'b0;
    ext_only = 1'b0;
    sfr(8'h58);
    wr_flash(16'h0010, 8'hA5, 1'b1);
    rdchk(16'h0010, 8'hA5);
    rdchk(16'h0011, 8'hFF);
    rdchk(16'h0050, 8'hFF);
    sfr(8'h18);
    wr_flash(16'h0010, 8'h0F, 1'b0);
    rdchk(16'h0010, 8'h05);
    sfr(8'h08);
    u_cpu.mv(1'b1, 1'b1, 16'h0010, 8'h00, 0);
    chk("busy_no_wen", 16'(busy), 16'h0);
    sfr(8'h10);
    u_cpu.mv(1'b1, 1'b1, 16'h0010, 8'h00, 0);
    chk("busy_no_flash", 16'(busy), 16'h0);
    sfr(8'h18);
    rdchk(16'h0010, 8'h05);
    u_cpu.mv(1'b0, 1'b0, 16'h0010, 8'h00, 0);
    chk("ptr8_target", 16'(u_cpu.tgt_q), 16'(fdm_pkg::TGT_EXT));
    // Buffered half-page write, each offset loaded once, mode cleared before commit
    sfr(8'h78);
    for (int i = 0; i < 7; i++)
    begin
      rnd();
      bufd[i] = lfsr[7:0];
      u_cpu.mv(1'b1, 1'b1, 16'(16'h0080 + i), bufd[i], int'(lfsr[9:8]));
      chk("busy_load", 16'(busy), 16'h0);
    end
    sfr(8'h58);
    wr_flash(16'h0087, 8'h3C, 1'b1);
    for (int i = 0; i < 7; i++)
      rdchk(16'(16'h0080 + i), bufd[i]);
    rdchk(16'h0087, 8'h3C);
    rdchk(16'h0088, 8'hFF);
    rdchk(16'h00C7, 8'hFF);
    rdchk(16'h0010, 8'h05);
    wr_flash(16'h0090, 8'h11, 1'b1);
    rdchk(16'h0080, 8'hFF);
    // Brown-out abort in mid-write, then a refused start
    sfr(8'h18);
    u_cpu.mv(1'b1, 1'b1, 16'h0020, 8'h00, 0);
    chk("busy_bo_start", 16'(busy), 16'h1);
    bo = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("busy_abort", 16'(busy), 16'h0);
    chk("ctrl_err", 16'(sfr_rdata), 16'h001C);
    u_cpu.mv(1'b1, 1'b1, 16'h0030, 8'h00, 0);
    chk("busy_refused", 16'(busy), 16'h0);
    bo = 1'b0;
    repeat (8) @(posedge clk);
    sfr(8'h1C);
    chk("err_kept", 16'(sfr_rdata), 16'h001D);
    sfr(8'h18);
    chk("err_cleared", 16'(sfr_rdata), 16'h0019);
    final_report();
  end
endmodule // flash_data_memory_ctrl_tb
